//--- hbgd_decoder.sv
// Functional notes
// - decode direction and pulse into four gates
// - disable forces gates off, diag lines released
// - overtemperature only warns on second diag line
// - undervoltage turns affected gates off, self-recovers
// - undervoltage: diag one low on output mismatch
// - diag two low while undervoltage affects output
// - short circuit latches affected half-bridge off
// - short circuit: diag one low, diag two high
// - shut-down node has both gates off
// - short disable clears diagnosis; long shuts down
// - short circuit latched only after continuous filter
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
`include "hbgd_defines.svh"

module hbgd_decoder (
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [`HBGD_ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// host pins
	input wire logic direction_in_i,
	input wire logic pulse_in_i,
	input wire logic deadtime_disable_in_i,
	// condition sensors
	input wire logic [3:0] undervoltage_cond_i,
	input wire logic overtemp_cond_i,
	input wire logic [1:0] short_circuit_cond_i,
	// gate commands
	output logic high_gate_one_o,
	output logic low_gate_one_o,
	output logic high_gate_two_o,
	output logic low_gate_two_o,
	// open-drain diagnosis lines
	output logic diag_line_one_o,
	output logic diag_line_one_oe_o,
	output logic diag_line_two_o,
	output logic diag_line_two_oe_o
);

	localparam int SYNC_W = 10;

	// two-stage synchronisers for the host pins and condition sensors
	logic [SYNC_W-1:0] sync1_ff;
	logic [SYNC_W-1:0] sync2_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= {direction_in_i, pulse_in_i, deadtime_disable_in_i,
				undervoltage_cond_i, overtemp_cond_i, short_circuit_cond_i};
			sync2_ff <= sync1_ff;
		end
	end

	wire dir_s = sync2_ff[9];
	wire pulse_s = sync2_ff[8];
	wire dis_s = sync2_ff[7];
	wire [3:0] uv_s = sync2_ff[6:3];
	wire ot_s = sync2_ff[2];
	wire [1:0] sc_s = sync2_ff[1:0];

	// input decode
	function automatic hbgd_pkg::hbgd_gates_type decode(input logic dir, input logic pulse);
		if (!pulse)
			decode = 4'h5; // both high sides on
		else if (!dir)
			decode = 4'h9; // high one, low two
		else
			decode = 4'h6; // low one, high two
	endfunction : decode

	// expand a per-node mask to both gates of each node
	function automatic hbgd_pkg::hbgd_gates_type node_mask(input hbgd_pkg::hbgd_nodes_type n);
		node_mask = {{2{n[1]}}, {2{n[0]}}};
	endfunction : node_mask

	// registers
	logic [`HBGD_DT_W-1:0] deadtime_ff;
	logic [`HBGD_FILT_W-1:0] scfilt_ff;
	logic [`HBGD_DIS_CNT_W-1:0] dis_cnt_ff;
	logic shut_ff;
	hbgd_pkg::hbgd_nodes_type sc_lat_ff;
	logic [`HBGD_FILT_W-1:0] sc_cnt_ff [2];
	hbgd_pkg::hbgd_gates_type gate_ff;
	logic [`HBGD_DT_W-1:0] dt_cnt_ff [2];
	logic diag1_ff;
	logic diag2_ff;
	logic ack_ff;
	logic [31:0] dat_ff;

	// fault and demand decoding
	wire hbgd_pkg::hbgd_gates_type demand = decode(dir_s, pulse_s);
	wire hbgd_pkg::hbgd_nodes_type uv_node = {|uv_s[3:2], |uv_s[1:0]};
	wire hbgd_pkg::hbgd_nodes_type dem_node = {|demand[3:2], |demand[1:0]};
	wire hbgd_pkg::hbgd_nodes_type uv_aff = uv_node & dem_node;
	wire hbgd_pkg::hbgd_nodes_type blocked = uv_node | sc_lat_ff;
	wire hbgd_pkg::hbgd_gates_type masked = demand & ~node_mask(blocked);
	wire hbgd_pkg::hbgd_gates_type target = dis_s ? 4'h0 : masked;
	wire mismatch = masked != demand;
	// diag one low on any mismatch, diag two low on undervoltage or bare warning
	wire nxt_diag1 = !dis_s && mismatch;
	wire nxt_diag2 = !dis_s && ((|uv_aff) || (ot_s && !mismatch));

	// disable pulse measurement: release inside the window clears diagnosis
	wire dis_cnt_sat = dis_cnt_ff >= `HBGD_DIS_CNT_W'(`HBGD_SHUTDOWN_CYC);
	wire diag_clear = !dis_s && dis_cnt_ff >= `HBGD_DIS_CNT_W'(`HBGD_DIAG_CLR_MIN_CYC)
		&& dis_cnt_ff <= `HBGD_DIS_CNT_W'(`HBGD_DIAG_CLR_MAX_CYC);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dis_cnt_ff <= '0;
			shut_ff <= 1'b0;
		end else begin
			dis_cnt_ff <= !dis_s ? '0 : dis_cnt_sat ? dis_cnt_ff : dis_cnt_ff + 1'b1;
			shut_ff <= dis_s && dis_cnt_sat;
		end
	end

	// short-circuit filter per half-bridge; a drop restarts the count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sc_lat_ff <= '0;
			for (int n = 0; n < 2; n++)
				sc_cnt_ff[n] <= '0;
		end else begin
			for (int n = 0; n < 2; n++) begin
				sc_cnt_ff[n] <= !sc_s[n] ? '0 : (sc_cnt_ff[n] >= scfilt_ff) ? sc_cnt_ff[n]
					: sc_cnt_ff[n] + 1'b1;
				// a new latch in the clear cycle wins
				if (sc_s[n] && sc_cnt_ff[n] >= scfilt_ff)
					sc_lat_ff[n] <= 1'b1;
				else if (diag_clear)
					sc_lat_ff[n] <= 1'b0;
			end
		end
	end

	// gate drive with dead time: turn-off is immediate, turn-on waits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gate_ff <= '0;
			for (int n = 0; n < 2; n++)
				dt_cnt_ff[n] <= '0;
		end else begin
			for (int n = 0; n < 2; n++) begin
				if (target[2*n +: 2] == gate_ff[2*n +: 2]) begin
					dt_cnt_ff[n] <= dt_cnt_ff[n];
				end else if (gate_ff[2*n +: 2] != 2'h0) begin
					gate_ff[2*n +: 2] <= 2'h0;
					dt_cnt_ff[n] <= deadtime_ff;
				end else if (dt_cnt_ff[n] != '0) begin
					dt_cnt_ff[n] <= dt_cnt_ff[n] - 1'b1;
				end else begin
					gate_ff[2*n +: 2] <= target[2*n +: 2];
				end
			end
		end
	end

	// diagnosis line drivers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			diag1_ff <= 1'b0;
			diag2_ff <= 1'b0;
		end else begin
			diag1_ff <= nxt_diag1;
			diag2_ff <= nxt_diag2;
		end
	end

	// wishbone decode; unmapped reads return zero, writes are dropped
	// writes land on the edge where the master sees ack, never earlier
	wire req = cyc_i && stb_i && !ack_ff;
	wire wr_ack = cyc_i && stb_i && we_i && ack_ff;
	wire wr_dt = wr_ack && sel_i[0] && adr_i == `HBGD_OFS_DEADTIME;
	wire wr_filt = wr_ack && adr_i == `HBGD_OFS_SCFILT;
	logic [31:0] status;
	always_comb begin
		status = '0;
		status[`HBGD_ST_SC_LO +: 2] = sc_lat_ff;
		status[`HBGD_ST_UV_LO +: 2] = uv_node;
		status[`HBGD_ST_OT] = ot_s;
		status[`HBGD_ST_DIS] = dis_s;
		status[`HBGD_ST_SHUT] = shut_ff;
	end
	wire [31:0] rd_mux = (adr_i == `HBGD_OFS_DEADTIME) ? {24'h000000, deadtime_ff}
		: (adr_i == `HBGD_OFS_SCFILT) ? {16'h0000, scfilt_ff}
		: (adr_i == `HBGD_OFS_STATUS) ? status : 32'h00000000;

	// one-wait-state answer; ack drops the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= '0;
			deadtime_ff <= `HBGD_DEADTIME_RST;
			scfilt_ff <= `HBGD_SCFILT_RST;
		end else begin
			ack_ff <= req;
			dat_ff <= (req && !we_i) ? rd_mux : 32'h00000000;
			if (wr_dt)
				deadtime_ff <= dat_i[`HBGD_DT_W-1:0];
			if (wr_filt && sel_i[0])
				scfilt_ff[7:0] <= dat_i[7:0];
			if (wr_filt && sel_i[1])
				scfilt_ff[15:8] <= dat_i[15:8];
		end
	end

	assign dat_o = dat_ff;
	assign ack_o = ack_ff;
	assign high_gate_one_o = gate_ff[0];
	assign low_gate_one_o = gate_ff[1];
	assign high_gate_two_o = gate_ff[2];
	assign low_gate_two_o = gate_ff[3];
	// open drain: only ever pull low
	assign diag_line_one_o = 1'b0;
	assign diag_line_one_oe_o = diag1_ff;
	assign diag_line_two_o = 1'b0;
	assign diag_line_two_oe_o = diag2_ff;

endmodule : hbgd_decoder

//--- hbgd_defines.svh
`ifndef HBGD_DEFINES_SVH
`define HBGD_DEFINES_SVH

// clock rate used to turn times into cycle counts
`define HBGD_CLK_MHZ 50
`define HBGD_NS_PER_US 1000

// disable-line timing windows, in nanoseconds as specified
`define HBGD_DIAG_CLR_MIN_NS 3100
`define HBGD_DIAG_CLR_MAX_NS 3600
`define HBGD_SHUTDOWN_NS 7000

// derived cycle counts: least time rounds up, longest time rounds down
`define HBGD_DIAG_CLR_MIN_CYC \
	((`HBGD_DIAG_CLR_MIN_NS * `HBGD_CLK_MHZ + `HBGD_NS_PER_US - 1) / `HBGD_NS_PER_US)
`define HBGD_DIAG_CLR_MAX_CYC ((`HBGD_DIAG_CLR_MAX_NS * `HBGD_CLK_MHZ) / `HBGD_NS_PER_US)
`define HBGD_SHUTDOWN_CYC \
	((`HBGD_SHUTDOWN_NS * `HBGD_CLK_MHZ + `HBGD_NS_PER_US - 1) / `HBGD_NS_PER_US)

// counter widths
`define HBGD_DIS_CNT_W 10
`define HBGD_DT_W 8
`define HBGD_FILT_W 16

// register byte offsets
`define HBGD_ADDR_W 4
`define HBGD_OFS_DEADTIME 4'h0
`define HBGD_OFS_SCFILT 4'h4
`define HBGD_OFS_STATUS 4'h8

// register reset values
`define HBGD_DEADTIME_RST 8'h05
`define HBGD_SCFILT_RST 16'h0064

// status bit positions
`define HBGD_ST_SC_LO 0
`define HBGD_ST_UV_LO 2
`define HBGD_ST_OT 4
`define HBGD_ST_DIS 5
`define HBGD_ST_SHUT 6

`endif

//--- hbgd_pkg.sv
package hbgd_pkg;
	// gate order: {low_gate_two, high_gate_two, low_gate_one, high_gate_one}
	typedef logic [3:0] hbgd_gates_type;
	// one bit per half-bridge: bit 0 node one, bit 1 node two
	typedef logic [1:0] hbgd_nodes_type;
endpackage : hbgd_pkg

//--- hbgd_decoder_asserts.sv
`timescale 1ns/10ps
module hbgd_decoder_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic deadtime_disable_in_i,
	input wire logic [3:0] undervoltage_cond_i,
	input wire logic overtemp_cond_i,
	input wire logic high_gate_one_o,
	input wire logic low_gate_one_o,
	input wire logic high_gate_two_o,
	input wire logic low_gate_two_o,
	input wire logic diag_line_one_oe_o,
	input wire logic diag_line_two_oe_o
);
	// short names: gates {gl2, gh2, gl1, gh1}, diag pull-downs, disable pin
	wire logic [3:0] g = {low_gate_two_o, high_gate_two_o, low_gate_one_o, high_gate_one_o};
	wire logic e1 = diag_line_one_oe_o;
	wire logic e2 = diag_line_two_oe_o;
	wire logic d = deadtime_disable_in_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// pins pass two sync stages and an output register, so causes hold four samples
	a_disable_all_off: assert property (d [*4] |-> g == 4'h0 && !e1 && !e2)
		else $error("disable not honoured");
	a_no_shoot_through: assert property (!(g[0] && g[1]) && !(g[2] && g[3]))
		else $error("both gates of a node on");
	a_dead_node_one: assert property ($fell(g[1]) |=> !g[0] [*5])
		else $error("dead time short on node one");
	a_dead_node_two: assert property ($fell(g[2]) |=> !g[3] [*5])
		else $error("dead time short on node two");
	a_ack_one_cycle: assert property (ack_o |=> !ack_o)
		else $error("ack held too long");
	a_ack_one_wait: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack late");
	a_temp_warn_only: assert property ((overtemp_cond_i && !d) [*4] ##0 !e1 |-> e2)
		else $error("no overtemperature warning");
	a_uv_node_off: assert property ((|undervoltage_cond_i[1:0] && !d) [*4]
		|-> e1 && e2 && g[1:0] == 2'h0)
		else $error("undervoltage not reported");
	// main scenarios reached
	c_bus_ack: cover property (ack_o);
	c_short_class: cover property (e1 && !e2);
	c_uv_class: cover property (e1 && e2);
endmodule : hbgd_decoder_asserts
bind hbgd_decoder hbgd_decoder_asserts chk (.*);

//--- hbgd_host_model.sv
`timescale 1ns/10ps
module hbgd_host_model (
	input wire logic clk_i,
	input wire logic fast_i,
	input wire logic dir_i,
	input wire logic pwm_i,
	output logic direction_o = 1'b0,
	output logic pulse_o = 1'b0
);
	// fast decay: pulse stays high and the pwm pattern goes out on direction
	always @(posedge clk_i) begin
		direction_o <= fast_i ? pwm_i : dir_i;
		pulse_o <= fast_i | pwm_i;
	end
endmodule : hbgd_host_model

//--- hbgd_decoder_bench.sv
`timescale 1ns/10ps
module hbgd_decoder_bench;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
	logic dis = 1'b0, ot = 1'b0, fast = 1'b0, dc = 1'b0, pwm = 1'b0, dw, pw, oe1, oe2;
	logic [3:0] adr_i = 4'h0, sel_i = 4'hf, uv = 4'h0, bsel = 4'hf;
	wire [3:0] g;
	logic [31:0] dat_i = 32'h0, seed = 32'h0000f245, dat_o, rd, r;
	logic [1:0] sc = 2'h0, lat = 2'h0;
	int n_mismatch = 0, checked = 0;
	hbgd_decoder uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.direction_in_i(dw), .pulse_in_i(pw), .deadtime_disable_in_i(dis),
		.undervoltage_cond_i(uv), .overtemp_cond_i(ot), .short_circuit_cond_i(sc),
		.high_gate_one_o(g[0]), .low_gate_one_o(g[1]), .high_gate_two_o(g[2]),
		.low_gate_two_o(g[3]), .diag_line_one_o(), .diag_line_one_oe_o(oe1),
		.diag_line_two_o(), .diag_line_two_oe_o(oe2));
	hbgd_host_model host (.clk_i, .fast_i(fast), .dir_i(dc), .pwm_i(pwm), .direction_o(dw),
		.pulse_o(pw));
	// 50 MHz clock
	initial forever #10 clk_i = ~clk_i;
	// xorshift source, fixed seed for repeatable runs
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// expected {diag one, diag two, gates} for pins, faults and latched shorts
	function automatic logic [5:0] want(logic d, p, o, logic [3:0] u, logic [1:0] s);
		logic [3:0] dm, gt;
		dm = !p ? 4'h5 : (d ? 4'h6 : 4'h9);
		gt = dm & {{2{!(|u[3:2] || s[1])}}, {2{!(|u[1:0] || s[0])}}};
		return {gt != dm, |u || (o && gt == dm), gt};
	endfunction : want
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one classic cycle; the wait has no fixed length, the watchdog bounds it
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		sel_i <= bsel;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : bus
	// settle past sync, dead time and host register, then compare
	task automatic pins(input int n);
		repeat (n) @(posedge clk_i);
		#1 check({oe1, oe2, g}, want(fast ? pwm : dc, fast | pwm, ot, uv, lat));
	endtask : pins
	task automatic results();
		$display("mismatches %0d, checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	// registers, random pin traffic, then short, filter and disable sequences
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b1, 4'h0, 32'h1a6);
		bus(1'b0, 4'h0, 32'h0);
		check(rd, 32'ha6);
		bsel = 4'he;
		bus(1'b1, 4'h0, 32'h5);
		bus(1'b0, 4'h0, 32'h0);
		check(rd, 32'ha6);
		bsel = 4'hf;
		bus(1'b1, 4'h0, 32'h5);
		bus(1'b0, 4'h0, 32'h0);
		check(rd, 32'h5);
		bus(1'b0, 4'h4, 32'h0);
		check(rd, 32'h64);
		bus(1'b1, 4'h8, 32'hffffffff);
		bus(1'b0, 4'h8, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, 4'hc, 32'h0);
		check(rd, 32'h0);
		for (int i = 0; i < 40; i++) begin
			@(posedge clk_i);
			r = rnd();
			{fast, dc, pwm, ot} <= r[3:0];
			uv <= r[5:4] == 2'h0 ? r[11:8] : 4'h0;
			pins(14);
		end
		@(posedge clk_i);
		{fast, dc, pwm, ot, uv, sc} <= 10'h081;
		repeat (120) @(posedge clk_i);
		sc <= 2'h0;
		lat = 2'h1;
		pins(10);
		repeat (2) begin
			@(posedge clk_i);
			sc <= 2'h2;
			repeat (60) @(posedge clk_i);
			sc <= 2'h0;
		end
		pins(10);
		@(posedge clk_i);
		dis <= 1'b1;
		repeat (170) @(posedge clk_i);
		dis <= 1'b0;
		lat = 2'h0;
		pins(14);
		@(posedge clk_i);
		{dis, ot, uv} <= 6'h3f;
		repeat (400) @(posedge clk_i);
		#1 check({oe1, oe2, g}, 6'h0);
		bus(1'b0, 4'h8, 32'h0);
		check(rd, 32'h7c);
		@(posedge clk_i);
		{dis, ot, uv} <= 6'h02;
		pins(14);
		@(posedge clk_i);
		uv <= 4'h0;
		pins(14);
		results();
	end
	// watchdog: the sequence needs about 1500 cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		results();
	end
endmodule : hbgd_decoder_bench
